/* File: include/qet_defs.vh */
// Constants for the quick-channel event tracking block
`ifndef QET_DEFS_VH
`define QET_DEFS_VH
`define QET_NCH 8
`define QET_NREG 2
`define QET_AW 12
`define QET_PAW 14
`define QET_OFF_EVENT 8'h00
`define QET_OFF_ENABLE 8'h04
`define QET_OFF_EN_CLR 8'h08
`define QET_OFF_EN_SET 8'h0C
`define QET_OFF_INQ 8'h10
`define QET_OFF_INQ_CLR 8'h14
`define QET_OFF_MISSED 8'h18
`define QET_OFF_IRQ_MASK 8'h1C
`define QET_OFF_RAE0 8'h20
`define QET_OFF_MAP0 8'h40
`define QET_OFF_MAP_LAST 8'h5C
`define QET_REGION_LSB 8
`define QET_REGION_GLOBAL 4'h0
`define QET_RESP_OKAY 2'h0
`define QET_RESP_SLVERR 2'h2
`define QET_RST_CH 8'h00
`define QET_RST_MAP 12'h000
`define QET_RST_WORD 32'h00000000
`endif

/* File: src/qet_axil.v */
// AXI4-Lite slave front end for the quick-channel event tracking block
`timescale 1ns/1ps
`include "qet_defs.vh"
module qet_axil (
	input wire clk_sys,
	input wire sys_rst,
	input wire [`QET_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`QET_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg wr_go_q,
	output reg [`QET_AW-1:0] wr_addr_q,
	output reg [31:0] wr_data_q,
	output reg [3:0] wr_strb_q,
	input wire wr_err,
	output reg rd_go_q,
	output reg [`QET_AW-1:0] rd_addr_q,
	input wire [31:0] rd_data,
	input wire rd_err
);
	reg aw_have_q;
	reg w_have_q;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	// Write starts once both halves are held and no response is pending
	wire wr_go_d = aw_have_q & w_have_q & ~s_axi_bvalid & ~wr_go_q;
	wire aw_have_d = aw_hs | (aw_have_q & ~wr_go_d);
	wire w_have_d = w_hs | (w_have_q & ~wr_go_d);
	wire rvalid_d = rd_go_q | (s_axi_rvalid & ~s_axi_rready);

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `QET_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `QET_RESP_OKAY;
			s_axi_rdata <= `QET_RST_WORD;
			wr_go_q <= 1'b0;
			wr_addr_q <= {`QET_AW{1'b0}};
			wr_data_q <= `QET_RST_WORD;
			wr_strb_q <= 4'h0;
			rd_go_q <= 1'b0;
			rd_addr_q <= {`QET_AW{1'b0}};
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			// Address is held until the write has been carried out
			s_axi_awready <= ~aw_have_d;
			s_axi_wready <= ~w_have_d;
			if (aw_hs) begin
				wr_addr_q <= s_axi_awaddr;
			end
			if (w_hs) begin
				wr_data_q <= s_axi_wdata;
				wr_strb_q <= s_axi_wstrb;
			end
			wr_go_q <= wr_go_d;
			if (wr_go_q) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `QET_RESP_SLVERR : `QET_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			rd_go_q <= ar_hs;
			if (ar_hs) begin
				rd_addr_q <= s_axi_araddr;
			end
			s_axi_arready <= ~ar_hs & ~rvalid_d;
			s_axi_rvalid <= rvalid_d;
			if (rd_go_q) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `QET_RESP_SLVERR : `QET_RESP_OKAY;
			end
		end
	end
endmodule // qet_axil

/* File: src/qet_event_tracking.v */
// Quick-channel event tracking: trigger detection, flags, arbitration, registers
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "qet_defs.vh"
module qet_event_tracking (
	input wire clk_sys,
	input wire sys_rst,
	input wire [`QET_AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`QET_AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire pe_wr_en,
	input wire [`QET_PAW-1:0] pe_wr_addr,
	input wire link_wr_en,
	input wire [`QET_PAW-1:0] link_wr_addr,
	output reg tr_req_valid,
	output reg [2:0] tr_req_chan,
	input wire tr_req_ready,
	input wire tc_sub_en,
	input wire [2:0] tc_sub_chan,
	input wire tc_sub_null,
	output reg irq
);
	localparam ST_IDLE = 2'b01;
	localparam ST_REQ = 2'b10;

	wire wr_go;
	wire [`QET_AW-1:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire rd_go;
	wire [`QET_AW-1:0] rd_addr;
	reg wr_err;
	reg rd_err;
	reg [31:0] rd_data;

	reg [`QET_NCH-1:0] event_q;
	reg [`QET_NCH-1:0] enable_q;
	reg [`QET_NCH-1:0] inq_q;
	reg [`QET_NCH-1:0] missed_q;
	reg [`QET_NCH-1:0] irq_mask_q;
	reg [`QET_NCH*`QET_NREG-1:0] rae_q;
	reg [12*`QET_NCH-1:0] map_q;
	reg [1:0] state_q;
	reg [1:0] state_d;

	wire [`QET_NCH-1:0] event_d;
	wire [`QET_NCH-1:0] enable_d;
	wire [`QET_NCH-1:0] inq_d;
	wire [`QET_NCH-1:0] missed_d;
	wire [`QET_NCH-1:0] take;

	qet_axil u_axil (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_go_q(wr_go),
		.wr_addr_q(wr_addr),
		.wr_data_q(wr_data),
		.wr_strb_q(wr_strb),
		.wr_err(wr_err),
		.rd_go_q(rd_go),
		.rd_addr_q(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Region decode: bit 9 global, bit 8 region exists, low byte channel mask
	function [9:0] region_of;
		input [`QET_AW-1:0] a;
		input [`QET_NCH*`QET_NREG-1:0] rae;
		reg [3:0] r;
		integer k;
		begin
			r = a[`QET_AW-1:`QET_REGION_LSB];
			region_of = {2'b00, `QET_RST_CH};
			if (r == `QET_REGION_GLOBAL) begin
				region_of = {2'b11, ~`QET_RST_CH};
			end
			for (k = 0; k < `QET_NREG; k = k + 1) begin
				if (r == k[3:0] + 4'h1) begin
					region_of = {2'b01, rae[k*`QET_NCH +: `QET_NCH]};
				end
			end
		end
	endfunction

	// Shadow regions only expose the six channel registers
	function addr_ok;
		input [9:0] reg_info;
		input [7:0] off;
		begin
			if (!reg_info[8]) begin
				addr_ok = 1'b0;
			end else if (off <= `QET_OFF_INQ_CLR) begin
				addr_ok = 1'b1;
			end else if (!reg_info[9]) begin
				addr_ok = 1'b0;
			end else if (off == `QET_OFF_MISSED || off == `QET_OFF_IRQ_MASK) begin
				addr_ok = 1'b1;
			end else if (off[7:2] < `QET_OFF_RAE0 / 4 + `QET_NREG && off >= `QET_OFF_RAE0) begin
				addr_ok = 1'b1;
			end else begin
				addr_ok = off >= `QET_OFF_MAP0 && off <= `QET_OFF_MAP_LAST;
			end
		end
	endfunction

	wire [9:0] wreg = region_of(wr_addr, rae_q);
	wire [9:0] rreg = region_of(rd_addr, rae_q);
	wire [7:0] woff = wr_addr[7:0];
	wire [7:0] roff = rd_addr[7:0];
	wire wr_ok = wr_go & addr_ok(wreg, woff) & (woff[1:0] == 2'b00);
	wire [7:0] wbits = wr_data[7:0] & {8{wr_strb[0]}} & wreg[7:0];
	wire [7:0] rmask = rreg[7:0];
	wire w_en_clr = wr_ok & (woff == `QET_OFF_EN_CLR);
	wire w_en_set = wr_ok & (woff == `QET_OFF_EN_SET);
	wire w_inq_clr = wr_ok & (woff == `QET_OFF_INQ_CLR);
	// Missed flags clear on a global read, which doubles as interrupt acknowledge
	wire rd_missed = rd_go & rreg[9] & (roff == `QET_OFF_MISSED);
	wire hw_take = tr_req_valid & tr_req_ready;

	genvar i;
	generate
		for (i = 0; i < `QET_NCH; i = i + 1) begin : g_ch
			wire [11:0] map_w = map_q[12*i +: 12];
			wire bus_hit = pe_wr_en & (pe_wr_addr[`QET_PAW-1:2] == map_w);
			wire link_hit = link_wr_en & (link_wr_addr[`QET_PAW-1:2] == map_w);
			wire set_ev = (bus_hit | link_hit) & enable_q[i];
			wire hw_clr = tc_sub_en & (tc_sub_chan == i);
			wire sw_clr = w_inq_clr & wbits[i];
			assign event_d[i] = set_ev | (event_q[i] & ~hw_clr & ~sw_clr);
			assign missed_d[i] = (set_ev & event_q[i]) | (missed_q[i] & ~rd_missed);
			assign enable_d[i] = (enable_q[i] | (w_en_set & wbits[i])) & ~(w_en_clr & wbits[i]);
			// in-queue set on hand-off, hardware clear for valid requests
			assign inq_d[i] = (take[i] & hw_take) |
				(inq_q[i] & ~(hw_clr & ~tc_sub_null) & ~sw_clr);
			assign take[i] = (tr_req_chan == i);
		end
	endgenerate

	// lowest eligible channel wins; queued channels are skipped
	wire [`QET_NCH-1:0] eligible = event_q & ~inq_q;
	reg [2:0] pick;
	integer n;
	always @* begin
		pick = 3'h0;
		for (n = `QET_NCH - 1; n >= 0; n = n - 1) begin
			if (eligible[n]) begin
				pick = n[2:0];
			end
		end
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (|eligible) begin
					state_d = ST_REQ;
				end
			end
			ST_REQ: begin
				if (tr_req_ready) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// read mux: reserved and write-only read zero
	always @* begin
		rd_err = ~addr_ok(rreg, roff) | (roff[1:0] != 2'b00);
		rd_data = `QET_RST_WORD;
		case (roff)
			`QET_OFF_EVENT: rd_data[7:0] = event_q & rmask;
			`QET_OFF_ENABLE: rd_data[7:0] = enable_q & rmask;
			`QET_OFF_INQ: rd_data[7:0] = inq_q & rmask;
			`QET_OFF_MISSED: rd_data[7:0] = missed_q;
			`QET_OFF_IRQ_MASK: rd_data[7:0] = irq_mask_q;
			default: begin
				if (roff >= `QET_OFF_RAE0 && roff < `QET_OFF_MAP0) begin
					rd_data[7:0] = rae_q[roff[4:2]*`QET_NCH +: `QET_NCH];
				end else if (roff >= `QET_OFF_MAP0 && roff <= `QET_OFF_MAP_LAST) begin
					rd_data[13:2] = map_q[roff[4:2]*12 +: 12];
				end
			end
		endcase
		if (rd_err) begin
			rd_data = `QET_RST_WORD;
		end
	end

	always @* begin
		wr_err = ~addr_ok(wreg, woff) | (woff[1:0] != 2'b00);
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			event_q <= `QET_RST_CH;
			enable_q <= `QET_RST_CH;
			inq_q <= `QET_RST_CH;
			missed_q <= `QET_RST_CH;
			irq_mask_q <= `QET_RST_CH;
			rae_q <= {`QET_NREG{`QET_RST_CH}};
			map_q <= {`QET_NCH{`QET_RST_MAP}};
			state_q <= ST_IDLE;
			tr_req_valid <= 1'b0;
			tr_req_chan <= 3'h0;
			irq <= 1'b0;
		end else begin
			event_q <= event_d;
			enable_q <= enable_d;
			inq_q <= inq_d;
			missed_q <= missed_d;
			// request issue to the queue hand-off
			state_q <= state_d;
			tr_req_valid <= state_d == ST_REQ;
			if (state_q == ST_IDLE) begin
				tr_req_chan <= pick;
			end
			irq <= |(missed_d & irq_mask_q);
			if (wr_ok && woff == `QET_OFF_IRQ_MASK && wr_strb[0]) begin
				irq_mask_q <= wr_data[7:0];
			end
			if (wr_ok && woff >= `QET_OFF_RAE0 && woff < `QET_OFF_MAP0 && wr_strb[0]) begin
				rae_q[woff[4:2]*`QET_NCH +: `QET_NCH] <= wr_data[7:0];
			end
			if (wr_ok && woff >= `QET_OFF_MAP0 && woff <= `QET_OFF_MAP_LAST) begin
				if (wr_strb[0]) begin
					map_q[woff[4:2]*12 +: 6] <= wr_data[7:2];
				end
				if (wr_strb[1]) begin
					map_q[woff[4:2]*12+6 +: 6] <= wr_data[13:8];
				end
			end
		end
	end
endmodule // qet_event_tracking

/* File: verif/qet_event_tracking_chk.sv */
// Port checker for the quick-channel event tracking block
`timescale 1ns/1ps
module qet_chk (
	input wire clk_sys,
	input wire sys_rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tr_req_valid,
	input wire [2:0] tr_req_chan,
	input wire tr_req_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_ANSWER: assert property (s_wr_both |=> !s_axi_bvalid ##[1:2] s_axi_bvalid)
		else $error("write answer timing");
	AST_RD_ANSWER: assert property (s_rd_take |=> !s_axi_rvalid ##[1:2] s_axi_rvalid)
		else $error("read answer timing");
	AST_AW_BLOCK: assert property (s_wr_both |=> !s_axi_awready && !s_axi_wready)
		else $error("write channel not closed");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	AST_R_RELEASE: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid ##[0:1] s_axi_arready)
		else $error("read channel not reopened");
	AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_OFFER_HOLD: assert property (tr_req_valid && !tr_req_ready |=>
		tr_req_valid && $stable(tr_req_chan))
		else $error("offer dropped or changed");
	AST_OFFER_DROP: assert property (tr_req_valid && tr_req_ready |=> !tr_req_valid)
		else $error("queued channel offered again");
endmodule // qet_chk

bind qet_event_tracking qet_chk u_chk (.*);

/* File: verif/qet_far_model.sv */
// Far side: trigger writers, request queue and transfer controller
`timescale 1ns/1ps
module qet_far_model (
	input wire clk_sys,
	output reg pe_wr_en = 1'b0,
	output reg [13:0] pe_wr_addr = 14'h0,
	output reg link_wr_en = 1'b0,
	output reg [13:0] link_wr_addr = 14'h0,
	output reg tr_req_ready = 1'b0,
	output reg tc_sub_en = 1'b0,
	output reg [2:0] tc_sub_chan = 3'h0,
	output reg tc_sub_null = 1'b0
);
	reg stall = 1'b0;
	// Queue may stall so an offer must wait
	always @(posedge clk_sys) tr_req_ready <= !stall;
	// Released address lines invert so a stale match never lingers
	task trig(input link, input [13:0] a);
		begin
			@(posedge clk_sys);
			if (link) begin
				link_wr_en <= 1'b1;
				link_wr_addr <= a;
			end else begin
				pe_wr_en <= 1'b1;
				pe_wr_addr <= a;
			end
			@(posedge clk_sys);
			pe_wr_en <= 1'b0;
			link_wr_en <= 1'b0;
			pe_wr_addr <= ~pe_wr_addr;
			link_wr_addr <= ~link_wr_addr;
		end
	endtask
	// null submission leaves in-queue flag to software
	task sub(input [2:0] c, input nul);
		begin
			@(posedge clk_sys);
			tc_sub_en <= 1'b1;
			tc_sub_chan <= c;
			tc_sub_null <= nul;
			@(posedge clk_sys);
			tc_sub_en <= 1'b0;
			tc_sub_chan <= ~c;
		end
	endtask
endmodule // qet_far_model

/* File: verif/tb.sv */
// Self-checking bench for the quick-channel event tracking block
`timescale 1ns/1ps
module tb;
	reg clk_sys = 1'b0;
	reg sys_rst = 1'b1;
	reg [11:0] s_axi_awaddr = 12'h0;
	reg [11:0] s_axi_araddr = 12'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire pe_wr_en, link_wr_en, tr_req_valid, tr_req_ready, tc_sub_en, tc_sub_null, irq;
	wire [13:0] pe_wr_addr, link_wr_addr;
	wire [2:0] tr_req_chan, tc_sub_chan;
	integer error_cnt = 0;
	integer check_count = 0;
	reg [11:0] i;
	always #20 clk_sys = ~clk_sys;
	qet_event_tracking u_dut (.*);
	qet_far_model u_far (.*);
	function [13:0] ta(input [2:0] c);
		ta = {9'h020, c, 2'h0};
	endfunction
	task give_verdict;
		begin
			if (error_cnt == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			check_count = check_count + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("mismatch at %0t: got %h expected %h", $time, s, e);
			end
		end
	endtask
	task tmo(input integer n);
		if (n == 40) begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	endtask
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		integer n;
		begin
			@(posedge clk_sys);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge clk_sys);
				if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
				if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid === 1'b1) begin
					chk(s_axi_bresp, er);
					s_axi_bready <= 1'b0;
					n = 99;
				end
			end
			tmo(n);
		end
	endtask
	task rd(input [11:0] a, input [31:0] e, input [1:0] er);
		integer n;
		begin
			@(posedge clk_sys);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 40; n = n + 1) begin
				@(posedge clk_sys);
				if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid === 1'b1) begin
					chk(s_axi_rdata, e);
					chk(s_axi_rresp, er);
					s_axi_rready <= 1'b0;
					n = 99;
				end
			end
			tmo(n);
		end
	endtask
	task offer(input [2:0] c);
		integer n;
		begin
			for (n = 0; n < 40 && tr_req_valid !== 1'b1; n = n + 1)
				@(posedge clk_sys);
			chk(tr_req_chan, c);
			tmo(n);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (i = 0; i < 10; i = i + 1)
			rd(i * 12'h4, 32'h0, 2'h0);
		rd(12'h30, 32'h0, 2'h2);
		for (i = 0; i < 8; i = i + 1)
			wr(12'h40 + i * 12'h4, {18'h0, ta(i[2:0])}, 2'h0);
		rd(12'h5C, {18'h0, ta(3'h7)}, 2'h0);
		u_far.trig(1'b0, ta(3'h2));
		rd(12'h00, 32'h0, 2'h0);
		wr(12'h0C, 32'hA5, 2'h0);
		rd(12'h04, 32'hA5, 2'h0);
		wr(12'h0C, 32'h0, 2'h0);
		wr(12'h08, 32'h05, 2'h0);
		wr(12'h08, 32'h0, 2'h0);
		wr(12'h04, 32'h0, 2'h0);
		rd(12'h04, 32'hA0, 2'h0);
		wr(12'h0C, 32'hFF, 2'h0);
		rd(12'h08, 32'h0, 2'h0);
		wr(12'h1C, 32'h08, 2'h0);
		u_far.stall <= 1'b1;
		u_far.trig(1'b0, ta(3'h3));
		rd(12'h00, 32'h08, 2'h0);
		offer(3'h3);
		u_far.stall <= 1'b0;
		rd(12'h10, 32'h08, 2'h0);
		u_far.trig(1'b0, ta(3'h1));
		u_far.trig(1'b0, ta(3'h3));
		rd(12'h00, 32'h0A, 2'h0);
		chk(irq, 1'b1);
		rd(12'h18, 32'h08, 2'h0);
		rd(12'h18, 32'h0, 2'h0);
		chk(irq, 1'b0);
		rd(12'h10, 32'h0A, 2'h0);
		u_far.sub(3'h3, 1'b0);
		rd(12'h00, 32'h02, 2'h0);
		rd(12'h10, 32'h02, 2'h0);
		wr(12'h14, 32'h02, 2'h0);
		rd(12'h00, 32'h0, 2'h0);
		rd(12'h10, 32'h0, 2'h0);
		u_far.trig(1'b0, ta(3'h5));
		rd(12'h10, 32'h20, 2'h0);
		u_far.sub(3'h5, 1'b1);
		rd(12'h00, 32'h0, 2'h0);
		rd(12'h10, 32'h20, 2'h0);
		wr(12'h14, 32'h20, 2'h0);
		rd(12'h10, 32'h0, 2'h0);
		u_far.trig(1'b1, ta(3'h6));
		rd(12'h00, 32'h40, 2'h0);
		u_far.sub(3'h6, 1'b0);
		u_far.trig(1'b0, ta(3'h4));
		rd(12'h00, 32'h10, 2'h0);
		fork
			u_far.trig(1'b0, ta(3'h4));
			u_far.sub(3'h4, 1'b0);
		join
		rd(12'h00, 32'h10, 2'h0);
		chk(irq, 1'b0);
		rd(12'h18, 32'h10, 2'h0);
		fork
			u_far.trig(1'b0, ta(3'h0));
			u_far.sub(3'h0, 1'b0);
		join
		rd(12'h00, 32'h11, 2'h0);
		rd(12'h18, 32'h0, 2'h0);
		wr(12'h20, 32'h10, 2'h0);
		rd(12'h104, 32'h10, 2'h0);
		rd(12'h118, 32'h0, 2'h2);
		wr(12'h208, 32'h10, 2'h0);
		rd(12'h04, 32'hFF, 2'h0);
		wr(12'h30, 32'h1, 2'h2);
		give_verdict;
	end
endmodule // tb
